// ===== design/pstr_cfg.svh
// pstr_cfg.svh: register offsets, fields, codes and reset values
// assumes: included by bare name from the package and the top
`ifndef PSTR_CFG_SVH
`define PSTR_CFG_SVH
// byte offsets on the register bus
`define PSTR_ADR_MODE 8'h00
`define PSTR_ADR_PTYPE 8'h04
`define PSTR_ADR_PSRC 8'h08
`define PSTR_ADR_PLVL 8'h0c
`define PSTR_ADR_PALIGN 8'h10
`define PSTR_ADR_PDELAY 8'h14
`define PSTR_ADR_PTERM 8'h18
`define PSTR_ADR_XSTAGE 8'h1c
`define PSTR_ADR_XTERM 8'h20
`define PSTR_ADR_COMMIT 8'h24
`define PSTR_ADR_STATUS 8'h28
`define PSTR_ADR_XDEST 8'h2c
// field positions
`define PSTR_MODE_ACQ 0
`define PSTR_MODE_RUN 1
`define PSTR_STAT_PAUSE 0
`define PSTR_STAT_XACT 1
// setting codes
`define PSTR_CODE_OFF 8'h1c
`define PSTR_CODE_LEVEL 8'h1e
`define PSTR_CODE_PATTERN 8'h1f
`define PSTR_CODE_HIGH 8'h22
`define PSTR_CODE_LOW 8'h23
`define PSTR_CODE_RISE 8'h12
`define PSTR_CODE_FALL 8'h13
`define PSTR_CODE_DELAY 8'h14
`define PSTR_CODE_DIFF 8'h40
`define PSTR_CODE_SE 8'h41
// source index layout: front panel, backplane, timing bus, star
`define PSTR_SRC_BP 5'h04
`define PSTR_SRC_TB 5'h0c
`define PSTR_SRC_STAR 5'h14
`define PSTR_NSRC 21
// export mask: 4 front panel, 7 backplane, 7 timing bus
`define PSTR_DEST_W 18
// reset values
`define PSTR_RST_DELAY 8'h00
`define PSTR_RST_DEST 18'h00000
`endif

// ===== design/pstr_export.sv
// pstr_export: drives the script trigger onto committed lines
// assumes: dest holds the committed mask, acq low means generation
`timescale 1ns/1ns
`default_nettype none
module pstr_export (
   input wire logic mclk_i,
   input wire logic nrst_i,
   pstr_if.xpt bus
);
   import pstr_pkg::*;
   typedef struct packed {
      logic [`PSTR_DEST_W-1:0] xout;
      logic [`PSTR_DEST_W-1:0] xoe;
   } pstr_xst_t;
   pstr_xst_t s, next_s;
   // drive only in generation; an empty mask leaves all lines floating
   always_comb begin
      next_s = s;
      next_s.xoe = bus.acq ? '0 : bus.dest; // R8 R9
      next_s.xout = next_s.xoe & {`PSTR_DEST_W{bus.script}}; // R8
   end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign bus.xout = s.xout;
   assign bus.xoe = s.xoe;
endmodule
`default_nettype wire

// ===== design/pstr_if.sv
// pstr_if: settings and results passed between top and its parts
// assumes: one top drives the settings, two parts answer
`timescale 1ns/1ns
`default_nettype none
interface pstr_if;
   import pstr_pkg::*;
   logic acq, run, lvl_high, smpl, pat_hit, script, pause, store;
   pstr_ptype_t ptype;
   pstr_align_t align;
   logic [4:0] src;
   logic [7:0] delay;
   logic [`PSTR_NSRC-1:0] lines;
   logic [`PSTR_DEST_W-1:0] dest, xout, xoe;
   modport ctl(output acq, run, lvl_high, smpl, pat_hit, script, ptype,
      align, src, delay, lines, dest, input pause, store, xout, xoe);
   modport pse(input acq, run, lvl_high, smpl, pat_hit, ptype, align,
      src, delay, lines, output pause, store);
   modport xpt(input acq, dest, script, output xout, xoe);
endinterface
`default_nettype wire

// ===== design/pstr_pause.sv
// pstr_pause: pause trigger conditioning and sample store gate
// assumes: sample clock arrives as a level synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module pstr_pause (
   input wire logic mclk_i,
   input wire logic nrst_i,
   pstr_if.pse bus
);
   import pstr_pkg::*;
   typedef struct packed {
      logic smpl_d;
      logic armed;
      logic [7:0] cnt;
      logic pause;
      logic store;
   } pstr_pst_t;
   pstr_pst_t s, next_s;
   logic rise, fall, hit, upd;
   // condition the selected source and step the pause flag
   always_comb begin
      next_s = s;
      next_s.smpl_d = bus.smpl;
      rise = bus.smpl & ~s.smpl_d;
      fall = ~bus.smpl & s.smpl_d;
      hit = bus.lvl_high ? bus.lines[bus.src] : ~bus.lines[bus.src]; // R6
      upd = rise;
      if (bus.src < `PSTR_SRC_BP) begin // R7
         unique case (bus.align)
            PSTR_RISE: upd = rise;
            PSTR_FALL: upd = fall;
            PSTR_DELAY: upd = s.armed && s.cnt == 8'h00;
            default: upd = rise; // unused code
         endcase
      end
      // delay count restarts on each rising sample edge
      if (rise) begin
         next_s.armed = 1'b1;
         next_s.cnt = bus.delay;
      end else if (s.armed) begin
         next_s.armed = s.cnt != 8'h00;
         next_s.cnt = s.cnt - 8'h01;
      end
      unique case (bus.ptype)
         PSTR_OFF: next_s.pause = 1'b0; // R2
         PSTR_LEVEL: next_s.pause = bus.acq & (upd ? hit : s.pause); // R3 R5
         PSTR_PATTERN: next_s.pause = bus.acq & bus.pat_hit; // R4
         default: next_s.pause = 1'b0; // unused code
      endcase
      // store only on rising sample edges seen unpaused
      next_s.store = rise & bus.acq & bus.run & ~next_s.pause; // R11
   end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign bus.pause = s.pause;
   assign bus.store = s.store;
endmodule
`default_nettype wire

// ===== design/pstr_pkg.sv
// pstr_pkg: types shared by the trigger routing modules
// assumes: pstr_cfg.svh is on the include path
package pstr_pkg;
`include "pstr_cfg.svh"
   // pause trigger type as held inside the block
   typedef enum logic [1:0] {PSTR_OFF, PSTR_LEVEL, PSTR_PATTERN} pstr_ptype_t;
   // where the level pause is sampled against the sample clock
   typedef enum logic [1:0] {PSTR_RISE, PSTR_FALL, PSTR_DELAY} pstr_align_t;
endpackage

// ===== design/pstr_top.sv
// pstr_top: pause trigger selection and script trigger export
// with a classic Wishbone register slave
// assumes: all inputs synchronous to MCLK_I; the sample clock is
// seen as a level and its edges are found here at mclk rate
`timescale 1ns/1ns
`default_nettype none
`include "pstr_cfg.svh"

// What this block does
// (R1) Pause type: codes 28 off, 30 level, 31 pattern
// (R2) Type off never pauses the operation
// (R3) Level mode: pause inactive until source level reached
// (R4) Pattern mode pauses on match, acquisition only
// (R5) Level source: front, backplane, timing, star lines
// (R6) Active level: 34 high, 35 low
// (R7) Front-panel alignment: 18 rise, 19 fall, 20 delay
// (R8) Export script trigger to chosen lines, generation only
// (R9) Committing empty destination releases the lines
// (R10) Terminal standard: 64 differential, 65 single-ended
// (R11) Paused acquisition stops storing; resumes next edge
module pstr_top (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // data path timing
   input wire logic SMPL_CLK_I,
   input wire logic PATTERN_HIT_I,
   input wire logic SCRIPT_TRIG_I,
   // trigger lines in
   input wire logic [3:0] FP_LINE_I,
   input wire logic [7:0] BP_TRIG_I,
   input wire logic [7:0] TB_LINE_I,
   input wire logic BP_STAR_I,
   // trigger lines out
   output logic [3:0] FP_LINE_O,
   output logic [3:0] FP_LINE_OE_O,
   output logic [6:0] BP_TRIG_O,
   output logic [6:0] BP_TRIG_OE_O,
   output logic [6:0] TB_LINE_O,
   output logic [6:0] TB_LINE_OE_O,
   // conditioned results
   output logic PAUSE_O,
   output logic SAMPLE_STORE_O,
   // terminal standards, high selects differential
   output logic PAUSE_TERM_DIFF_O,
   output logic XPT_TERM_DIFF_O
);
   import pstr_pkg::*;

   // ----------
   // state
   // ----------
   typedef struct packed {
      logic acq; // acquisition when set, else generation
      logic run; // operation running
      pstr_ptype_t ptype; // pause type in force
      logic [4:0] src; // level pause source index
      logic lvl_high; // pause while source high
      pstr_align_t align; // sample clock alignment
      logic [7:0] delay; // mclk cycles after rising edge
      logic pterm_diff; // pause terminal differential
      logic xterm_diff; // export terminal differential
      logic [`PSTR_DEST_W-1:0] xstage; // staged export mask
      logic [`PSTR_DEST_W-1:0] xdest; // committed export mask
      logic ack; // bus answer
      logic [31:0] dat; // bus read data
   } pstr_st_t;

   pstr_st_t s, next_s;
   logic req; // new bus request this cycle
   logic [7:0] adr; // word aligned byte address
   logic [31:0] wval; // old register value merged with write
   logic pause_q; // pause flag from the conditioning part
   logic store_q; // store pulse from the conditioning part
   logic [`PSTR_DEST_W-1:0] xout_q; // export levels
   logic [`PSTR_DEST_W-1:0] xoe_q; // export enables

   pstr_if bus ();

   // ----------
   // helpers
   // ----------

   // register readback; also feeds the byte merge on writes
   function automatic logic [31:0] rd(input pstr_st_t c,
      input logic [7:0] a, input logic p,
      input logic [`PSTR_DEST_W-1:0] oe);
      logic [31:0] v;
      v = 32'h00000000;
      unique case (a)
         `PSTR_ADR_MODE: begin
            v[`PSTR_MODE_ACQ] = c.acq;
            v[`PSTR_MODE_RUN] = c.run;
         end
         `PSTR_ADR_PTYPE: begin
            unique case (c.ptype)
               PSTR_LEVEL: v[7:0] = `PSTR_CODE_LEVEL;
               PSTR_PATTERN: v[7:0] = `PSTR_CODE_PATTERN;
               default: v[7:0] = `PSTR_CODE_OFF;
            endcase
         end
         `PSTR_ADR_PSRC: v[4:0] = c.src;
         `PSTR_ADR_PLVL: begin
            v[7:0] = c.lvl_high ? `PSTR_CODE_HIGH : `PSTR_CODE_LOW;
         end
         `PSTR_ADR_PALIGN: begin
            unique case (c.align)
               PSTR_FALL: v[7:0] = `PSTR_CODE_FALL;
               PSTR_DELAY: v[7:0] = `PSTR_CODE_DELAY;
               default: v[7:0] = `PSTR_CODE_RISE;
            endcase
         end
         `PSTR_ADR_PDELAY: v[7:0] = c.delay;
         `PSTR_ADR_PTERM: v[7:0] = tcode(c.pterm_diff);
         `PSTR_ADR_XTERM: v[7:0] = tcode(c.xterm_diff);
         `PSTR_ADR_XSTAGE: v[`PSTR_DEST_W-1:0] = c.xstage;
         `PSTR_ADR_XDEST: v[`PSTR_DEST_W-1:0] = c.xdest;
         `PSTR_ADR_STATUS: begin
            v[`PSTR_STAT_PAUSE] = p;
            v[`PSTR_STAT_XACT] = |oe;
         end
         default: v = 32'h00000000; // unmapped reads as zero
      endcase
      return v;
   endfunction

   // code of a terminal standard
   function automatic logic [7:0] tcode(input logic diff);
      return diff ? `PSTR_CODE_DIFF : `PSTR_CODE_SE;
   endfunction

   // keep old bytes where the byte select is low
   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // decode a terminal standard code; unknown codes keep old value
   function automatic logic tstd(input logic [7:0] code,
      input logic old);
      logic r;
      r = old;
      if (code == `PSTR_CODE_DIFF) begin
         r = 1'b1;
      end else if (code == `PSTR_CODE_SE) begin
         r = 1'b0;
      end
      return r;
   endfunction

   // ----------
   // register slave
   // ----------
   assign adr = {WB_ADR_I[7:2], 2'b00};
   // the answer comes one cycle after the request is seen; the
   // not-ack term stops a held request from being taken twice
   assign req = WB_CYC_I & WB_STB_I & ~s.ack;
   assign wval = merge(rd(s, adr, pause_q, xoe_q), WB_DAT_I, WB_SEL_I);

   // decode writes, form the answer
   always_comb begin
      next_s = s;
      next_s.ack = req;
      next_s.dat = 32'h00000000;
      if (req && !WB_WE_I) begin
         next_s.dat = rd(s, adr, pause_q, xoe_q);
      end
      if (req && WB_WE_I) begin
         unique case (adr)
            `PSTR_ADR_MODE: begin
               next_s.acq = wval[`PSTR_MODE_ACQ];
               next_s.run = wval[`PSTR_MODE_RUN];
               // a pattern pause cannot stay armed in generation
               if (!wval[`PSTR_MODE_ACQ] && s.ptype == PSTR_PATTERN) begin
                  next_s.ptype = PSTR_OFF; // R4
               end
            end
            `PSTR_ADR_PTYPE: begin
               // unknown codes are ignored, old type stays
               if (wval[7:0] == `PSTR_CODE_OFF) begin
                  next_s.ptype = PSTR_OFF; // R1
               end else if (wval[7:0] == `PSTR_CODE_LEVEL) begin
                  next_s.ptype = PSTR_LEVEL; // R1
               end else if (wval[7:0] == `PSTR_CODE_PATTERN
                  && s.acq) begin
                  next_s.ptype = PSTR_PATTERN; // R1 R4
               end
            end
            `PSTR_ADR_PSRC: begin
               // only the 21 documented sources are taken
               if (wval[7:0] < 8'(`PSTR_NSRC)) begin
                  next_s.src = wval[4:0]; // R5
               end
            end
            `PSTR_ADR_PLVL: begin
               if (wval[7:0] == `PSTR_CODE_HIGH) begin
                  next_s.lvl_high = 1'b1; // R6
               end else if (wval[7:0] == `PSTR_CODE_LOW) begin
                  next_s.lvl_high = 1'b0; // R6
               end
            end
            `PSTR_ADR_PALIGN: begin
               if (wval[7:0] == `PSTR_CODE_RISE) begin
                  next_s.align = PSTR_RISE; // R7
               end else if (wval[7:0] == `PSTR_CODE_FALL) begin
                  next_s.align = PSTR_FALL; // R7
               end else if (wval[7:0] == `PSTR_CODE_DELAY) begin
                  next_s.align = PSTR_DELAY; // R7
               end
            end
            `PSTR_ADR_PDELAY: next_s.delay = wval[7:0];
            `PSTR_ADR_PTERM: begin
               next_s.pterm_diff = tstd(wval[7:0], s.pterm_diff); // R10
            end
            `PSTR_ADR_XTERM: begin
               next_s.xterm_diff = tstd(wval[7:0], s.xterm_diff); // R10
            end
            `PSTR_ADR_XSTAGE: begin
               // staging alone never moves a pin
               next_s.xstage = wval[`PSTR_DEST_W-1:0];
            end
            `PSTR_ADR_COMMIT: begin
               // an empty staged mask releases every line
               next_s.xdest = s.xstage; // R9
            end
            default: begin
               // read-only or unmapped: acked, nothing stored
            end
         endcase
      end
   end

   // register the whole state
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s <= '0;
         s.lvl_high <= 1'b1;
         s.delay <= `PSTR_RST_DELAY;
         s.xstage <= `PSTR_RST_DEST;
         s.xdest <= `PSTR_RST_DEST;
      end else begin
         s <= next_s;
      end
   end

   // ----------
   // parts
   // ----------
   assign bus.acq = s.acq;
   assign bus.run = s.run;
   assign bus.ptype = s.ptype;
   assign bus.src = s.src;
   assign bus.lvl_high = s.lvl_high;
   assign bus.align = s.align;
   assign bus.delay = s.delay;
   assign bus.dest = s.xdest;
   assign bus.smpl = SMPL_CLK_I;
   assign bus.pat_hit = PATTERN_HIT_I;
   assign bus.script = SCRIPT_TRIG_I;
   // source order: front panel 0-3, backplane 4-11, timing 12-19,
   // star 20
   assign bus.lines = {BP_STAR_I, TB_LINE_I, BP_TRIG_I, FP_LINE_I}; // R5
   assign pause_q = bus.pause;
   assign store_q = bus.store;
   assign xout_q = bus.xout;
   assign xoe_q = bus.xoe;

   // pause conditioning and store gate
   pstr_pause u_pause (
      .mclk_i(MCLK_I),
      .nrst_i(NRST_I),
      .bus(bus.pse)
   );

   // script trigger export
   pstr_export u_export (
      .mclk_i(MCLK_I),
      .nrst_i(NRST_I),
      .bus(bus.xpt)
   );

   // ----------
   // outputs, all from flip-flops
   // ----------
   assign WB_ACK_O = s.ack;
   assign WB_DAT_O = s.dat;
   assign PAUSE_O = pause_q;
   assign SAMPLE_STORE_O = store_q;
   assign FP_LINE_O = xout_q[3:0];
   assign FP_LINE_OE_O = xoe_q[3:0];
   assign BP_TRIG_O = xout_q[10:4];
   assign BP_TRIG_OE_O = xoe_q[10:4];
   assign TB_LINE_O = xout_q[17:11];
   assign TB_LINE_OE_O = xoe_q[17:11];
   assign PAUSE_TERM_DIFF_O = s.pterm_diff; // R10
   assign XPT_TERM_DIFF_O = s.xterm_diff; // R10
endmodule
`default_nettype wire

// ===== tb/pstr_far_end.sv
// pstr_far_end.sv: other instruments sharing the trigger lines
// assumes: a line nobody drives shows the far instruments' level
`timescale 1ns/1ns
`default_nettype none
module pstr_far_end (
   // levels the far instruments put on the lines
   input wire logic [3:0] ext_fp_i,
   input wire logic [7:0] ext_bp_i,
   input wire logic [7:0] ext_tb_i,
   input wire logic ext_star_i,
   // what the block drives, enable high while driving
   input wire logic [3:0] fp_drv_i,
   input wire logic [3:0] fp_en_i,
   input wire logic [6:0] bp_drv_i,
   input wire logic [6:0] bp_en_i,
   input wire logic [6:0] tb_drv_i,
   input wire logic [6:0] tb_en_i,
   // resolved wire levels
   output logic [3:0] fp_line_o,
   output logic [7:0] bp_line_o,
   output logic [7:0] tb_line_o,
   output logic star_line_o
);
   // ----------
   // wire resolution
   // ----------
   // released lines show the far level, so a stale drive is caught
   assign fp_line_o = (fp_en_i & fp_drv_i) | (~fp_en_i & ext_fp_i);
   // line 7 is never exported, the far side owns it alone
   assign bp_line_o = {ext_bp_i[7],
      (bp_en_i & bp_drv_i) | (~bp_en_i & ext_bp_i[6:0])};
   assign tb_line_o = {ext_tb_i[7],
      (tb_en_i & tb_drv_i) | (~tb_en_i & ext_tb_i[6:0])};
   assign star_line_o = ext_star_i;
endmodule
`default_nettype wire

// ===== tb/pstr_top_properties.sv
// pstr_top_properties.sv: port checks for the trigger routing top
// assumes: bound to every pstr_top, one clock, reset active low
`timescale 1ns/1ns
`default_nettype none
module pstr_chk (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // register bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // data path and lines
   input wire logic SMPL_CLK_I,
   input wire logic SCRIPT_TRIG_I,
   input wire logic [3:0] FP_LINE_O,
   input wire logic [3:0] FP_LINE_OE_O,
   input wire logic [6:0] BP_TRIG_O,
   input wire logic [6:0] BP_TRIG_OE_O,
   input wire logic [6:0] TB_LINE_O,
   input wire logic [6:0] TB_LINE_OE_O,
   input wire logic PAUSE_O,
   input wire logic SAMPLE_STORE_O
);
   // ----------
   // properties
   // ----------
   // one domain, so clock and reset are given once
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   // a request that is not yet answered
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   // one-cycle answer followed by a gap
   sequence s_ack;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   a_ack_next_cycle: assert property (s_req |=> s_ack)
      else $error("bus answer late or too long");
   a_read_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data outside the answer cycle");
   a_paused_no_store: assert property (SAMPLE_STORE_O |-> !PAUSE_O)
      else $error("sample stored while paused");
   a_store_on_edge: assert property (SAMPLE_STORE_O |->
      $past(SMPL_CLK_I) != $past(SMPL_CLK_I, 2) ||
      $past(SMPL_CLK_I, 2) != $past(SMPL_CLK_I, 3))
      else $error("store without a sample edge");
   a_store_one_pulse: assert property (SAMPLE_STORE_O |=> !SAMPLE_STORE_O)
      else $error("store pulse too long");
   a_fp_script_gate: assert property (FP_LINE_O ==
      (FP_LINE_OE_O & {4{$past(SCRIPT_TRIG_I)}}))
      else $error("front line export mismatch");
   a_bp_script_gate: assert property (BP_TRIG_O ==
      (BP_TRIG_OE_O & {7{$past(SCRIPT_TRIG_I)}}))
      else $error("backplane export mismatch");
   a_tb_script_gate: assert property (TB_LINE_O ==
      (TB_LINE_OE_O & {7{$past(SCRIPT_TRIG_I)}}))
      else $error("timing line export mismatch");
endmodule
bind pstr_top pstr_chk u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .SMPL_CLK_I(SMPL_CLK_I),
   .SCRIPT_TRIG_I(SCRIPT_TRIG_I), .FP_LINE_O(FP_LINE_O),
   .FP_LINE_OE_O(FP_LINE_OE_O), .BP_TRIG_O(BP_TRIG_O),
   .BP_TRIG_OE_O(BP_TRIG_OE_O), .TB_LINE_O(TB_LINE_O),
   .TB_LINE_OE_O(TB_LINE_OE_O), .PAUSE_O(PAUSE_O),
   .SAMPLE_STORE_O(SAMPLE_STORE_O));
`default_nettype wire

// ===== tb/testbench.sv
// testbench.sv: scenarios for the pause and export block
// assumes: design files and pstr_cfg.svh compiled before this one
`timescale 1ns/1ns
`default_nettype none
`include "pstr_cfg.svh"
module testbench;
   logic MCLK_I, NRST_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
   logic [7:0] WB_ADR_I;
   logic [3:0] WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O;
   logic SMPL_CLK_I, PATTERN_HIT_I, SCRIPT_TRIG_I, star_i, ext_star;
   logic [3:0] fp_i, ext_fp, FP_LINE_O, FP_LINE_OE_O;
   logic [7:0] bp_i, tb_i, ext_bp, ext_tb;
   logic [6:0] BP_TRIG_O, BP_TRIG_OE_O, TB_LINE_O, TB_LINE_OE_O;
   logic PAUSE_O, SAMPLE_STORE_O, PAUSE_TERM_DIFF_O, XPT_TERM_DIFF_O;
   int bad_count = 0, num_checks = 0, stores = 0, cycles = 0;
   // ----------
   // block, far side and helpers
   // ----------
   pstr_top u_dut (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
      .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
      .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
      .SMPL_CLK_I(SMPL_CLK_I), .PATTERN_HIT_I(PATTERN_HIT_I),
      .SCRIPT_TRIG_I(SCRIPT_TRIG_I), .FP_LINE_I(fp_i),
      .BP_TRIG_I(bp_i), .TB_LINE_I(tb_i), .BP_STAR_I(star_i),
      .FP_LINE_O(FP_LINE_O), .FP_LINE_OE_O(FP_LINE_OE_O),
      .BP_TRIG_O(BP_TRIG_O), .BP_TRIG_OE_O(BP_TRIG_OE_O),
      .TB_LINE_O(TB_LINE_O), .TB_LINE_OE_O(TB_LINE_OE_O),
      .PAUSE_O(PAUSE_O), .SAMPLE_STORE_O(SAMPLE_STORE_O),
      .PAUSE_TERM_DIFF_O(PAUSE_TERM_DIFF_O),
      .XPT_TERM_DIFF_O(XPT_TERM_DIFF_O));
   pstr_far_end u_far (.ext_fp_i(ext_fp), .ext_bp_i(ext_bp),
      .ext_tb_i(ext_tb), .ext_star_i(ext_star), .fp_drv_i(FP_LINE_O),
      .fp_en_i(FP_LINE_OE_O), .bp_drv_i(BP_TRIG_O),
      .bp_en_i(BP_TRIG_OE_O), .tb_drv_i(TB_LINE_O),
      .tb_en_i(TB_LINE_OE_O), .fp_line_o(fp_i), .bp_line_o(bp_i),
      .tb_line_o(tb_i), .star_line_o(star_i));
   // 100 ns clock
   initial begin
      MCLK_I = 1'b0;
      forever #50 MCLK_I = ~MCLK_I;
   end
   // count stores and cut a hang short
   always @(posedge MCLK_I) begin
      if (SAMPLE_STORE_O === 1'b1) stores <= stores + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // one classic cycle, held until the answer edge
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge MCLK_I);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      do @(posedge MCLK_I);
      while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   // a refused code must leave the good one in place
   task automatic cfg_try(input logic [7:0] a, input logic [7:0] g,
      input logic [7:0] b);
      wr(a, {24'h0, g});
      wr(a, {24'h0, b});
      rd_chk(a, {24'h0, g});
   endtask
   task automatic drive(input int i, input logic v);
      @(posedge MCLK_I);
      if (i < 4) ext_fp[i] <= v;
      else if (i < 12) ext_bp[i-4] <= v;
      else if (i < 20) ext_tb[i-12] <= v;
      else ext_star <= v;
   endtask
   task automatic half(input logic v);
      @(posedge MCLK_I);
      SMPL_CLK_I <= v;
      repeat (4) @(posedge MCLK_I);
   endtask
   task automatic samp(input logic e);
      half(1'b0);
      half(1'b1);
      check(PAUSE_O, e);
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_reset();
      rd_chk(`PSTR_ADR_MODE, 32'h0);
      rd_chk(`PSTR_ADR_PTYPE, 32'h1c);
      rd_chk(`PSTR_ADR_PLVL, 32'h22);
      rd_chk(`PSTR_ADR_PALIGN, 32'h12);
      rd_chk(`PSTR_ADR_PTERM, 32'h41);
      rd_chk(`PSTR_ADR_XTERM, 32'h41);
      rd_chk(`PSTR_ADR_XDEST, 32'h0);
      wr(8'h30, 32'h5);
      rd_chk(8'h30, 32'h0);
   endtask
   task automatic t_codes();
      cfg_try(`PSTR_ADR_PTYPE, 8'h1e, 8'h1d);
      wr(`PSTR_ADR_PTYPE, 32'h1f);
      rd_chk(`PSTR_ADR_PTYPE, 32'h1e);
      cfg_try(`PSTR_ADR_PLVL, 8'h23, 8'h24);
      cfg_try(`PSTR_ADR_PALIGN, 8'h14, 8'h15);
      cfg_try(`PSTR_ADR_PSRC, 8'h14, 8'h15);
      cfg_try(`PSTR_ADR_PTERM, 8'h40, 8'h42);
      cfg_try(`PSTR_ADR_XTERM, 8'h40, 8'h3f);
      check({PAUSE_TERM_DIFF_O, XPT_TERM_DIFF_O}, 2'b11);
      wr(`PSTR_ADR_PTERM, 32'h41);
      wr(`PSTR_ADR_XTERM, 32'h41);
      wr(`PSTR_ADR_PLVL, 32'h22);
      wr(`PSTR_ADR_PALIGN, 32'h12);
      check({PAUSE_TERM_DIFF_O, XPT_TERM_DIFF_O}, 2'b00);
   endtask
   task automatic t_level();
      int srcs[6] = '{0, 4, 11, 12, 19, 20};
      int s;
      wr(`PSTR_ADR_MODE, 32'h3);
      wr(`PSTR_ADR_PTYPE, 32'h1e);
      foreach (srcs[k]) begin
         wr(`PSTR_ADR_PSRC, srcs[k]);
         drive(srcs[k], 1'b1);
         s = stores;
         samp(1'b1);
         check(stores, s);
         drive(srcs[k], 1'b0);
         samp(1'b0);
         check(stores, s + 1);
      end
      wr(`PSTR_ADR_PLVL, 32'h23);
      samp(1'b1);
      rd_chk(`PSTR_ADR_STATUS, 32'h1);
      wr(`PSTR_ADR_PLVL, 32'h22);
      samp(1'b0);
   endtask
   task automatic t_align();
      wr(`PSTR_ADR_PSRC, 32'h3);
      wr(`PSTR_ADR_PALIGN, 32'h13);
      half(1'b0);
      drive(3, 1'b1);
      half(1'b1);
      check(PAUSE_O, 1'b0);
      samp(1'b1);
      wr(`PSTR_ADR_PALIGN, 32'h14);
      wr(`PSTR_ADR_PDELAY, 32'h6);
      drive(3, 1'b0);
      half(1'b0);
      @(posedge MCLK_I);
      SMPL_CLK_I <= 1'b1;
      repeat (8) @(posedge MCLK_I);
      check(PAUSE_O, 1'b1);
      @(posedge MCLK_I);
      check(PAUSE_O, 1'b0);
   endtask
   task automatic t_pattern_off();
      int s;
      cfg_try(`PSTR_ADR_PTYPE, 8'h1f, 8'h1d);
      PATTERN_HIT_I <= 1'b1;
      repeat (3) @(posedge MCLK_I);
      check(PAUSE_O, 1'b1);
      wr(`PSTR_ADR_MODE, 32'h0);
      rd_chk(`PSTR_ADR_PTYPE, 32'h1c);
      check(PAUSE_O, 1'b0);
      wr(`PSTR_ADR_MODE, 32'h3);
      wr(`PSTR_ADR_PALIGN, 32'h12);
      drive(3, 1'b1);
      s = stores;
      samp(1'b0);
      check(stores, s + 1);
      PATTERN_HIT_I <= 1'b0;
   endtask
   task automatic t_export();
      wr(`PSTR_ADR_MODE, 32'h0);
      ext_fp <= 4'ha;
      wr(`PSTR_ADR_XSTAGE, 32'hc01);
      rd_chk(`PSTR_ADR_XDEST, 32'h0);
      wr(`PSTR_ADR_COMMIT, 32'h0);
      rd_chk(`PSTR_ADR_XDEST, 32'hc01);
      rd_chk(`PSTR_ADR_STATUS, 32'h2);
      SCRIPT_TRIG_I <= 1'b1;
      repeat (2) @(posedge MCLK_I);
      check({fp_i, bp_i[6], tb_i[0]}, 6'h2f);
      wr(`PSTR_ADR_MODE, 32'h1);
      @(posedge MCLK_I);
      check(FP_LINE_OE_O, 4'h0);
      wr(`PSTR_ADR_MODE, 32'h0);
      wr(`PSTR_ADR_XSTAGE, 32'h0);
      wr(`PSTR_ADR_COMMIT, 32'h0);
      @(posedge MCLK_I);
      check({FP_LINE_OE_O, BP_TRIG_OE_O, TB_LINE_OE_O}, 18'h0);
      check(fp_i, 4'ha);
   endtask
   // main sequence
   initial begin
      NRST_I = 1'b0;
      WB_CYC_I = 1'b0;
      WB_STB_I = 1'b0;
      WB_WE_I = 1'b0;
      WB_ADR_I = 8'h00;
      WB_SEL_I = 4'hf;
      WB_DAT_I = 32'h0;
      SMPL_CLK_I = 1'b0;
      PATTERN_HIT_I = 1'b0;
      SCRIPT_TRIG_I = 1'b0;
      {ext_fp, ext_bp, ext_tb, ext_star} = 21'h0;
      repeat (3) @(posedge MCLK_I);
      NRST_I <= 1'b1;
      t_reset();
      t_codes();
      t_level();
      t_align();
      t_pattern_off();
      t_export();
      end_of_test();
   end
endmodule
`default_nettype wire
